// ===== inc/ttic_pkg.sv
`default_nettype none
package ttic_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indexes; the byte address is four times the index
    localparam logic [9:0] IDX_CONFIG    = 10'h030;
    localparam logic [9:0] IDX_STATUS    = 10'h031;
    localparam logic [9:0] IDX_ADDR_CTRL = 10'h032;
    localparam logic [9:0] IDX_DATA_BUF  = 10'h033;

    localparam logic [7:0] CONFIG_RST    = 8'h00;
    localparam logic [7:0] ADDR_CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_BUF_RST  = 8'h00;

    // Configuration, status and address/control fields
    localparam int CFG_PER_SLOT_EN_BIT = 0;
    localparam int CFG_WINDOW_MODE_BIT = 1;
    localparam int CFG_CAS_SEL_BIT     = 2;
    localparam int STATUS_BUSY_BIT     = 7;
    localparam int AC_DIR_BIT          = 7;

    // Data-control byte fields
    localparam int CTRL_REPLACE_BIT = 7;
    localparam int CTRL_PSEL_LO_BIT = 6;
    localparam int CTRL_PSEL_HI_BIT = 5;
    localparam int CTRL_SIGNALING_SOURCE_BIT  = 4;

    // Internal address map
    localparam logic [6:0] CTRL_BASE = 7'h20;
    localparam logic [6:0] CTRL_LAST = 7'h3F;
    localparam logic [6:0] IDLE_BASE = 7'h40;
    localparam logic [6:0] IDLE_LAST = 7'h5F;

    // Inversion masks; slot bit 1 is byte bit 7
    localparam logic [7:0] MASK_ODD_SLOT_BITS  = 8'hAA;
    localparam logic [7:0] MASK_EVEN_SLOT_BITS = 8'h55;
    localparam logic [7:0] MASK_ALL_BITS       = 8'hFF;

    // Milliwatt sequences, first entry first
    localparam logic [0:7][7:0] MW_ALAW = {8'h34, 8'h21, 8'h21, 8'h34,
                                           8'hB4, 8'hA1, 8'hA1, 8'hB4};
    localparam logic [0:7][7:0] MW_MULAW = {8'h1E, 8'h0B, 8'h0B, 8'h1E,
                                            8'h9E, 8'h8B, 8'h8B, 8'h9E};

    // Access timing
    localparam int ACCESS_TIME_NS = 480;
    localparam int CLK_PERIOD_NS  = 8;
    localparam int ACCESS_MAX_CYC = ACCESS_TIME_NS / CLK_PERIOD_NS;

    typedef enum {ACC_IDLE, ACC_RUN, ACC_CAPTURE} ttic_acc_state_t;

endpackage : ttic_pkg
`default_nettype wire

// ===== rtl/ttic_mw_seq.sv
`timescale 1ns/1ns
`default_nettype none
module ttic_mw_seq
    import ttic_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Control
    input  wire logic       advance_in,
    input  wire logic       law_mu_in,
    // Pattern byte
    output logic      [7:0] mw_byte_out
);

    logic [2:0] phase_q;

    // Wraps from the eighth entry to the first by overflow
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_q <= 3'h0;
        end else if (advance_in) begin
            phase_q <= phase_q + 3'h1;
        end
    end

    assign mw_byte_out = law_mu_in ? MW_MULAW[phase_q] : MW_ALAW[phase_q];

    AST_MW_WRAP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        advance_in && phase_q == 3'h7 |=> phase_q == 3'h0)
        else $error("Milliwatt phase did not wrap to first entry");

endmodule : ttic_mw_seq
`default_nettype wire

// ===== rtl/ttic_slot_mem.sv
`timescale 1ns/1ns
`default_nettype none
module ttic_slot_mem #(
    parameter int DATA_W = 8,
    parameter int DEPTH  = 32,
    parameter int ADDR_W = 5
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    // Host port
    input  wire logic [ADDR_W-1:0] a_addr_in,
    input  wire logic              a_we_in,
    input  wire logic [DATA_W-1:0] a_wdata_in,
    output logic      [DATA_W-1:0] a_rdata_out,
    // Transmit path port
    input  wire logic [ADDR_W-1:0] b_addr_in,
    output logic      [DATA_W-1:0] b_rdata_out
);

    logic [DATA_W-1:0] mem_q [DEPTH];

    // Cleared at reset so untouched slots pass data unchanged
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (a_we_in) begin
            mem_q[a_addr_in] <= a_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            a_rdata_out <= '0;
            b_rdata_out <= '0;
        end else begin
            a_rdata_out <= mem_q[a_addr_in];
            b_rdata_out <= mem_q[b_addr_in];
        end
    end

endmodule : ttic_slot_mem
`default_nettype wire

// ===== rtl/ttic_top.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Writing address/control with valid address starts one internal access.
// - Direction 1 reads the addressed byte; direction 0 writes the buffer into it.
// - Read data lands in the data buffer within 480 ns.
// - Internal 20H..3FH are data-control bytes of slots 0..31.
// - Internal 40H..5FH are idle-code bytes of slots 0..31.
// - Control byte: replace 7, select lo 6, select hi 5, source 4, alt bits 3..0.
// - Replace 0, selects 0: slot byte passes unchanged.
// - Replace 0, lo 0, hi 1: invert slot bits 1,3,5,7.
// - Replace 0, lo 1, hi 0: invert slot bits 2,4,6,8.
// - Replace 0, both selects 1: invert all eight bits.
// - Replace 1, lo 0: idle code replaces the slot byte.
// - Replace 1, lo 1, hi 0: A-law milliwatt sequence replaces data.
// - Replace 1, both selects 1: mu-law milliwatt sequence replaces data.
// - Signaling source bit counts only when channel associated signaling selected.
// - Source 0 takes backplane signaling; source 1 takes the alternate bits.
// - Address/control and data buffer reset to zero.
// - Busy high during an access, low after; host polls before next.
// - Per-slot enable 0 disables every per-slot function.
// - Idle code goes out most significant bit first.
module ttic_top
    import ttic_pkg::*;
(
    // Clock and reset
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_N_IN,
    // APB slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // Backplane slot stream
    input  wire logic        SLOT_VALID_IN,
    input  wire logic [4:0]  SLOT_NUM_IN,
    input  wire logic [7:0]  BACKPLANE_PCM_IN,
    input  wire logic [3:0]  BACKPLANE_SIGNALING_IN,
    // Outgoing slot stream
    output logic             OUTGOING_VALID_OUT,
    output logic      [7:0]  OUTGOING_PCM_OUT,
    output logic      [3:0]  OUTGOING_SIG_OUT
);

    localparam int BUSY_LIMIT = ACCESS_MAX_CYC;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    logic [9:0]      apb_idx;
    logic            apb_setup;
    logic            apb_wr;
    logic [7:0]      config_q;
    logic [7:0]      addr_ctrl_q;
    logic [7:0]      data_buf_q;
    logic            busy_q;
    ttic_acc_state_t acc_state_q;
    logic            start_acc;
    logic            per_slot_en;
    logic            window_mode;
    logic            cas_en;

    assign apb_idx     = PADDR_IN[11:2];
    assign apb_setup   = PSEL_IN && !PENABLE_IN;
    assign apb_wr      = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = 1'b0;
    assign per_slot_en = config_q[CFG_PER_SLOT_EN_BIT];
    assign window_mode = config_q[CFG_WINDOW_MODE_BIT];
    assign cas_en      = config_q[CFG_CAS_SEL_BIT];

    // Requests written while busy are dropped, keeping the running access intact
    assign start_acc = apb_wr && apb_idx == IDX_ADDR_CTRL && !busy_q && window_mode;

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            config_q <= CONFIG_RST;
        end else if (apb_wr && apb_idx == IDX_CONFIG) begin
            config_q <= PWDATA_IN[7:0];
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            addr_ctrl_q <= ADDR_CTRL_RST;
        end else if (apb_wr && apb_idx == IDX_ADDR_CTRL && !busy_q) begin
            addr_ctrl_q <= PWDATA_IN[7:0];
        end
    end

    // Read data sampled in the setup phase, stable through the access phase
    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA_OUT <= 32'h0000_0000;
        end else if (apb_setup) begin
            case (apb_idx)
                IDX_CONFIG:    PRDATA_OUT <= {24'h00_0000, config_q};
                IDX_STATUS:    PRDATA_OUT <= {24'h00_0000, busy_q, 7'h00};
                IDX_ADDR_CTRL: PRDATA_OUT <= {24'h00_0000, addr_ctrl_q};
                IDX_DATA_BUF:  PRDATA_OUT <= {24'h00_0000, data_buf_q};
                default:       PRDATA_OUT <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Indirect access sequencer
    logic [6:0] int_addr;
    logic       acc_read;
    logic       in_ctrl;
    logic       in_idle;
    logic       ctrl_we;
    logic       idle_we;
    logic [7:0] ctrl_host_rd;
    logic [7:0] idle_host_rd;
    logic [7:0] cap_byte;

    assign int_addr = addr_ctrl_q[6:0];
    assign acc_read = addr_ctrl_q[AC_DIR_BIT];
    assign in_ctrl  = int_addr >= CTRL_BASE && int_addr <= CTRL_LAST;
    assign in_idle  = int_addr >= IDLE_BASE && int_addr <= IDLE_LAST;
    // Writes take the buffer byte the host loaded beforehand
    assign ctrl_we  = acc_state_q == ACC_RUN && !acc_read && in_ctrl;
    assign idle_we  = acc_state_q == ACC_RUN && !acc_read && in_idle;

    always_comb begin
        if (in_ctrl) begin
            cap_byte = ctrl_host_rd;
        end else if (in_idle) begin
            cap_byte = idle_host_rd;
        end else begin
            cap_byte = 8'h00;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            acc_state_q <= ACC_IDLE;
        end else begin
            case (acc_state_q)
                ACC_IDLE:    acc_state_q <= start_acc ? ACC_RUN : ACC_IDLE;
                ACC_RUN:     acc_state_q <= ACC_CAPTURE;
                ACC_CAPTURE: acc_state_q <= ACC_IDLE;
                default:     acc_state_q <= ACC_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else if (start_acc) begin
            busy_q <= 1'b1;
        end else if (acc_state_q == ACC_CAPTURE) begin
            busy_q <= 1'b0;
        end
    end

    // Completion of a read wins over a host write in the same cycle
    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            data_buf_q <= DATA_BUF_RST;
        end else if (acc_state_q == ACC_CAPTURE && acc_read) begin
            data_buf_q <= cap_byte;
        end else if (apb_wr && apb_idx == IDX_DATA_BUF) begin
            data_buf_q <= PWDATA_IN[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-slot stores
    logic [7:0] ctrl_byte;
    logic [7:0] idle_byte;

    ttic_slot_mem #(
        .DATA_W (8),
        .DEPTH  (32),
        .ADDR_W (5)
    ) u_ctrl_mem (
        .clk_in      (SYS_CLK_IN),
        .rst_n_in    (rst_n),
        .a_addr_in   (int_addr[4:0]),
        .a_we_in     (ctrl_we),
        .a_wdata_in  (data_buf_q),
        .a_rdata_out (ctrl_host_rd),
        .b_addr_in   (SLOT_NUM_IN),
        .b_rdata_out (ctrl_byte)
    );

    ttic_slot_mem #(
        .DATA_W (8),
        .DEPTH  (32),
        .ADDR_W (5)
    ) u_idle_mem (
        .clk_in      (SYS_CLK_IN),
        .rst_n_in    (rst_n),
        .a_addr_in   (int_addr[4:0]),
        .a_we_in     (idle_we),
        .a_wdata_in  (data_buf_q),
        .a_rdata_out (idle_host_rd),
        .b_addr_in   (SLOT_NUM_IN),
        .b_rdata_out (idle_byte)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path, stage one aligns with the store read
    logic       s1_valid_q;
    logic [7:0] s1_pcm_q;
    logic [3:0] s1_sig_q;
    logic       replace_enable;
    logic       pattern_select_lo;
    logic       pattern_select_hi;
    logic       signaling_source;
    logic       s1_is_mw;
    logic       mw_used_q;
    logic       mw_advance;
    logic [7:0] mw_byte;
    logic [7:0] pcm_d;
    logic [3:0] sig_d;

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            s1_valid_q <= 1'b0;
            s1_pcm_q   <= 8'h00;
            s1_sig_q   <= 4'h0;
        end else begin
            s1_valid_q <= SLOT_VALID_IN;
            s1_pcm_q   <= BACKPLANE_PCM_IN;
            s1_sig_q   <= BACKPLANE_SIGNALING_IN;
        end
    end

    assign replace_enable    = ctrl_byte[CTRL_REPLACE_BIT];
    assign pattern_select_lo = ctrl_byte[CTRL_PSEL_LO_BIT];
    assign pattern_select_hi = ctrl_byte[CTRL_PSEL_HI_BIT];
    assign signaling_source  = ctrl_byte[CTRL_SIGNALING_SOURCE_BIT];
    assign s1_is_mw          = s1_valid_q && per_slot_en && replace_enable && pattern_select_lo;

    // Phase moves at the first slot of the frame after any milliwatt use
    assign mw_advance = SLOT_VALID_IN && SLOT_NUM_IN == 5'h00 && (mw_used_q || s1_is_mw);

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            mw_used_q <= 1'b0;
        end else if (mw_advance) begin
            mw_used_q <= 1'b0;
        end else if (s1_is_mw) begin
            mw_used_q <= 1'b1;
        end
    end

    ttic_mw_seq u_mw_seq (
        .clk_in      (SYS_CLK_IN),
        .rst_n_in    (rst_n),
        .advance_in  (mw_advance),
        .law_mu_in   (pattern_select_hi),
        .mw_byte_out (mw_byte)
    );

    always_comb begin
        pcm_d = s1_pcm_q;
        sig_d = s1_sig_q;
        if (per_slot_en) begin
            if (!replace_enable) begin
                case ({pattern_select_lo, pattern_select_hi})
                    2'b00:   pcm_d = s1_pcm_q;
                    2'b01:   pcm_d = s1_pcm_q ^ MASK_ODD_SLOT_BITS;
                    2'b10:   pcm_d = s1_pcm_q ^ MASK_EVEN_SLOT_BITS;
                    default: pcm_d = s1_pcm_q ^ MASK_ALL_BITS;
                endcase
            end else if (!pattern_select_lo) begin
                pcm_d = idle_byte;
            end else begin
                pcm_d = mw_byte;
            end
            if (cas_en && signaling_source) begin
                sig_d = ctrl_byte[3:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            OUTGOING_VALID_OUT <= 1'b0;
            OUTGOING_PCM_OUT   <= 8'h00;
            OUTGOING_SIG_OUT   <= 4'h0;
        end else begin
            OUTGOING_VALID_OUT <= s1_valid_q;
            OUTGOING_PCM_OUT   <= pcm_d;
            OUTGOING_SIG_OUT   <= sig_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence seq_read_start;
        start_acc && PWDATA_IN[AC_DIR_BIT];
    endsequence

    // Busy drops at the second edge after the start, so it is seen low at the third
    sequence seq_read_done;
        ##3 !busy_q;
    endsequence

    AST_BUSY_ON_START: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
        start_acc |=> busy_q && acc_state_q == ACC_RUN)
        else $error("Access did not start after address write");

    AST_BUSY_BOUND: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
        $rose(busy_q) |-> ##[1:BUSY_LIMIT] !busy_q)
        else $error("Busy held beyond the access time");

    AST_READ_COMPLETES: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
        seq_read_start |-> seq_read_done)
        else $error("Read request not finished in time");

    AST_READ_FILLS_BUFFER: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
        acc_state_q == ACC_CAPTURE && acc_read |=> data_buf_q == $past(cap_byte))
        else $error("Data buffer missed the read byte");

    AST_OUT_OF_RANGE_ZERO: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
        acc_state_q == ACC_CAPTURE && acc_read && !in_ctrl && !in_idle |=> data_buf_q == 8'h00)
        else $error("Out-of-range read returned nonzero");

    AST_NO_STRAY_WRITE: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
        ctrl_we || idle_we |-> int_addr >= CTRL_BASE && int_addr <= IDLE_LAST && !acc_read)
        else $error("Internal write outside the slot range");

    AST_NO_START_WINDOW_OFF: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
        !window_mode && acc_state_q == ACC_IDLE |=> acc_state_q == ACC_IDLE)
        else $error("Access started with window mode off");

    AST_PASS_DISABLED: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
        s1_valid_q && !per_slot_en |=> OUTGOING_PCM_OUT == $past(s1_pcm_q)
                                       && OUTGOING_SIG_OUT == $past(s1_sig_q))
        else $error("Slot altered with per-slot functions off");

    AST_INVERT_ALL: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
        s1_valid_q && per_slot_en && ctrl_byte[7:5] == 3'b011
        |=> OUTGOING_PCM_OUT == ~$past(s1_pcm_q))
        else $error("Full inversion not applied");

    AST_IDLE_SUBST: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
        s1_valid_q && per_slot_en && replace_enable && !pattern_select_lo
        |=> OUTGOING_PCM_OUT == $past(idle_byte))
        else $error("Idle code not substituted");

    AST_SIG_ALTERNATE: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n)
        s1_valid_q && per_slot_en && cas_en && signaling_source
        |=> OUTGOING_SIG_OUT == $past(ctrl_byte[3:0]))
        else $error("Alternate signaling bits not used");

endmodule : ttic_top
`default_nettype wire

// ===== sim/ttic_slot_src.sv
`timescale 1ns/1ns
`default_nettype none
module ttic_slot_src (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Control
    input  wire logic       go_in,
    input  wire logic [1:0] gap_in,
    // Slot stream
    output logic            valid_out,
    output logic      [4:0] slot_out,
    output logic      [7:0] pcm_out,
    output logic      [3:0] sig_out,
    output logic            busy_out
);
    integer     seed = 32'h6dc0;
    logic [1:0] wait_q;

    ////////////////////////////////////////////////////////////////////////////
    // One frame of 32 slots, optionally with random gaps between slots
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_out  <= 1'b0;
            valid_out <= 1'b0;
            slot_out  <= 5'h00;
            pcm_out   <= 8'h00;
            sig_out   <= 4'h0;
            wait_q    <= 2'h0;
        end else if (busy_out && wait_q == 2'h0) begin
            valid_out <= 1'b1;
            slot_out  <= slot_out + 5'h01;
            pcm_out   <= 8'($random(seed));
            sig_out   <= 4'($random(seed));
            wait_q    <= gap_in & 2'($random(seed));
            busy_out  <= slot_out != 5'h1E;
        end else begin
            // Idle data toggles so a stale byte never passes for a valid one
            valid_out <= 1'b0;
            pcm_out   <= ~pcm_out;
            sig_out   <= ~sig_out;
            if (wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end
            if (go_in && !busy_out) begin
                busy_out <= 1'b1;
                slot_out <= 5'h1F;
            end
        end
    end
endmodule : ttic_slot_src
`default_nettype wire

// ===== sim/ttic_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module ttic_top_test
    import ttic_pkg::*;
();
    localparam logic [11:0] A_CFG = {IDX_CONFIG, 2'b00};
    localparam logic [11:0] A_STS = {IDX_STATUS, 2'b00};
    localparam logic [11:0] A_ACS = {IDX_ADDR_CTRL, 2'b00};
    localparam logic [11:0] A_BUF = {IDX_DATA_BUF, 2'b00};
    localparam logic [63:0] ALAW  = 64'h34212134B4A1A1B4;
    localparam logic [63:0] MULAW = 64'h1E0B0B1E9E8B8B9E;

    logic        clk, rst_n, psel, pen, pwr, pready, pslverr;
    logic        go, svalid, sbusy, ovalid, mw_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0]  snum;
    logic [7:0]  spcm, opcm, cfg;
    logic [3:0]  ssig, osig;
    logic [1:0]  gap;
    logic [7:0]  ctl_m [32];
    logic [7:0]  idl_m [32];
    logic [11:0] exp_q [$];
    integer      seed = 32'h6dc0;
    int          errors, n_compared, cyc, ph;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ttic_top i_dut (
        .SYS_CLK_IN(clk), .RST_N_IN(rst_n),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .SLOT_VALID_IN(svalid), .SLOT_NUM_IN(snum), .BACKPLANE_PCM_IN(spcm),
        .BACKPLANE_SIGNALING_IN(ssig), .OUTGOING_VALID_OUT(ovalid),
        .OUTGOING_PCM_OUT(opcm), .OUTGOING_SIG_OUT(osig)
    );

    ttic_slot_src i_src (
        .clk_in(clk), .rst_n_in(rst_n), .go_in(go), .gap_in(gap), .valid_out(svalid),
        .slot_out(snum), .pcm_out(spcm), .sig_out(ssig), .busy_out(sbusy)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_byte

    task automatic chk_slot(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_slot

    ////////////////////////////////////////////////////////////////////////////
    // Idle cycle before each setup keeps psel from being driven twice at one edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= wr;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata[7:0];
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] e);
        logic [7:0] q;
        apb(1'b0, a, 8'h00, q);
        chk_byte(nm, e, q);
        chk_byte("pslverr", 8'h00, {7'h00, pslverr});
    endtask : rd_chk

    // Twenty polls of three cycles each span the 480 ns access time
    task automatic wait_idle;
        logic [7:0] q;
        int         n;
        n = 0;
        do begin
            apb(1'b0, A_STS, 8'h00, q);
            n++;
        end while (q[STATUS_BUSY_BIT] !== 1'b0 && n < 20);
        chk_byte("busy", 8'h00, q & 8'h80);
    endtask : wait_idle

    task automatic window_access_mode(input logic rd, input logic [6:0] a, input logic [7:0] d);
        if (!rd) wr(A_BUF, d);
        wr(A_ACS, {rd, a});
        wait_idle();
    endtask : window_access_mode

    task automatic frame;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        while (sbusy || svalid) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask : frame

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_pcm(input logic [7:0] c, input logic [7:0] i,
                                           input logic [7:0] p);
        if (!cfg[CFG_PER_SLOT_EN_BIT]) return p;
        case (c[7:5])
            3'b000: return p;
            3'b001: return p ^ 8'hAA;
            3'b010: return p ^ 8'h55;
            3'b011: return ~p;
            3'b110: return ALAW[63 - 8 * ph -: 8];
            3'b111: return MULAW[63 - 8 * ph -: 8];
            default: return i;
        endcase
    endfunction : exp_pcm

    function automatic logic [3:0] exp_sig(input logic [7:0] c, input logic [3:0] s);
        if (cfg[CFG_PER_SLOT_EN_BIT] && cfg[CFG_CAS_SEL_BIT] && c[CTRL_SIGNALING_SOURCE_BIT]) return c[3:0];
        return s;
    endfunction : exp_sig

    // Expectation is fixed when the slot enters; outputs come back in order
    always @(posedge clk) begin
        logic [7:0]  c;
        logic [11:0] e;
        cyc++;
        if (cyc > 20000) begin
            errors++;
            end_sim();
        end
        if (svalid) begin
            c = ctl_m[snum];
            if (snum == 5'h00 && mw_seen) begin
                ph = (ph + 1) % 8;
                mw_seen = 1'b0;
            end
            mw_seen = mw_seen | (cfg[CFG_PER_SLOT_EN_BIT] & c[7] & c[6]);
            exp_q.push_back({exp_sig(c, ssig), exp_pcm(c, idl_m[snum], spcm)});
        end
        if (ovalid) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hXXX;
            chk_slot("slot", e, {osig, opcm});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, pen, pwr, go, rst_n, mw_seen} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        gap = 2'h0;
        cfg = 8'h00;
        {errors, n_compared, cyc, ph} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk("addr_ctrl", A_ACS, 8'h00);
        rd_chk("data_buf", A_BUF, 8'h00);
        rd_chk("unmapped", 12'hFFC, 8'h00);
        wr(A_BUF, 8'hA5);
        wr(A_ACS, 8'h20);
        rd_chk("addr_ctrl", A_ACS, 8'h20);
        cfg = 8'h07;
        wr(A_CFG, cfg);
        rd_chk("config", A_CFG, cfg);
        window_access_mode(1'b1, 7'h20, 8'h00);
        rd_chk("ctrl_untouched", A_BUF, 8'h00);
        for (int n = 0; n < 32; n++) begin
            ctl_m[n] = {n[2:0], 5'($random(seed))};
            idl_m[n] = 8'($random(seed));
            window_access_mode(1'b0, 7'(CTRL_BASE + n), ctl_m[n]);
            window_access_mode(1'b0, 7'(IDLE_BASE + n), idl_m[n]);
        end
        window_access_mode(1'b0, 7'h1F, 8'hFF);
        window_access_mode(1'b0, 7'h60, 8'hFF);
        window_access_mode(1'b1, 7'h7F, 8'h00);
        rd_chk("out_of_range", A_BUF, 8'h00);
        for (int n = 0; n < 32; n++) begin
            window_access_mode(1'b1, 7'(CTRL_BASE + n), 8'h00);
            rd_chk("ctrl", A_BUF, ctl_m[n]);
            window_access_mode(1'b1, 7'(IDLE_BASE + n), 8'h00);
            rd_chk("idle", A_BUF, idl_m[n]);
        end
        for (int f = 0; f < 11; f++) begin
            if (f == 9) cfg = 8'h03;
            if (f == 10) cfg = 8'h06;
            wr(A_CFG, cfg);
            gap <= f[0] ? 2'h3 : 2'h0;
            frame();
        end
        chk_byte("pending", 8'h00, 8'(exp_q.size()));
        end_sim();
    end
endmodule : ttic_top_test
`default_nettype wire
